// File: bbo_pkg.sv
// branch and bit-ops unit: shared constants and types
package bbo_pkg;

  // =====================================================
  // status flag positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // =====================================================
  // reset values and constants
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] IO_ADDR_RST = 5'h00;

  // =====================================================
  // timing in core cycles
  localparam int CYC_SINGLE = 1;
  localparam int CYC_BR_TAKEN = 2;
  localparam int CYC_IO = 2;

  // =====================================================
  // operations
  typedef enum logic [5:0] {
    OP_NOP,
    OP_BR_EQUAL, OP_BR_NOT_EQUAL,
    OP_BR_CARRY_ONE, OP_BR_CARRY_ZERO,
    OP_BR_UNSIGNED_GE, OP_BR_UNSIGNED_LT,
    OP_BR_NEGATIVE, OP_BR_NONNEGATIVE,
    OP_BR_SIGNED_GE, OP_BR_SIGNED_LT,
    OP_BR_HALFCARRY_ONE, OP_BR_HALFCARRY_ZERO,
    OP_BR_TRANSFER_ONE, OP_BR_TRANSFER_ZERO,
    OP_BR_OVERFLOW_ONE, OP_BR_OVERFLOW_ZERO,
    OP_BR_IRQ_ON, OP_BR_IRQ_OFF,
    OP_BR_FLAG_ONE, OP_BR_FLAG_ZERO,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT, OP_NIBBLE_SWAP,
    OP_FLAG_SET_GENERIC, OP_FLAG_CLEAR_GENERIC,
    OP_BIT_TO_TRANSFER, OP_TRANSFER_TO_BIT,
    OP_IRQ_ENABLE, OP_IRQ_DISABLE,
    OP_SIGNED_FLAG_SET, OP_SIGNED_FLAG_CLEAR,
    OP_OVERFLOW_SET, OP_OVERFLOW_CLEAR,
    OP_CARRY_SET, OP_CARRY_CLEAR,
    OP_NEGATIVE_SET, OP_NEGATIVE_CLEAR,
    OP_ZERO_SET, OP_ZERO_CLEAR,
    OP_TRANSFER_SET, OP_TRANSFER_CLEAR,
    OP_HALFCARRY_SET, OP_HALFCARRY_CLEAR
  } bbo_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } bbo_state_t;

endpackage

// File: bbo_unit.sv
// branch, bit and shift execution unit of an 8-bit core
module bbo_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request from the sequencer
  input wire logic i_start,
  input wire bbo_pkg::bbo_op_t i_op,
  input wire logic [15:0] i_pc,
  input wire logic [6:0] i_offset,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_status_flags_register,
  input wire logic [7:0] i_reg_val,
  input wire logic [4:0] i_io_addr,
  input wire logic [7:0] i_io_val,
  // handshake
  output logic o_busy,
  output logic o_done,
  // program counter
  output logic [15:0] o_pc,
  output logic o_pc_load,
  // status flags
  output logic [7:0] o_status_flags_register,
  output logic o_status_flags_register_we,
  // working register
  output logic [7:0] o_reg_val,
  output logic o_reg_we,
  // i/o space
  output logic [4:0] o_io_addr,
  output logic [7:0] o_io_val,
  output logic o_io_we
);
  import bbo_pkg::*;

  // =====================================================
  // decode functions
  // {is_branch, signed_test, polarity, flag index}
  function automatic logic [5:0] br_dec(input bbo_op_t op,
                                        input logic [2:0] b);
    case (op)
      OP_BR_EQUAL: br_dec = {3'b101, FLG_Z};
      OP_BR_NOT_EQUAL: br_dec = {3'b100, FLG_Z};
      OP_BR_CARRY_ONE: br_dec = {3'b101, FLG_C};
      OP_BR_UNSIGNED_LT: br_dec = {3'b101, FLG_C};
      OP_BR_CARRY_ZERO: br_dec = {3'b100, FLG_C};
      OP_BR_UNSIGNED_GE: br_dec = {3'b100, FLG_C};
      OP_BR_NEGATIVE: br_dec = {3'b101, FLG_N};
      OP_BR_NONNEGATIVE: br_dec = {3'b100, FLG_N};
      OP_BR_SIGNED_GE: br_dec = {3'b110, FLG_N};
      OP_BR_SIGNED_LT: br_dec = {3'b111, FLG_N};
      OP_BR_HALFCARRY_ONE: br_dec = {3'b101, FLG_H};
      OP_BR_HALFCARRY_ZERO: br_dec = {3'b100, FLG_H};
      OP_BR_TRANSFER_ONE: br_dec = {3'b101, FLG_T};
      OP_BR_TRANSFER_ZERO: br_dec = {3'b100, FLG_T};
      OP_BR_OVERFLOW_ONE: br_dec = {3'b101, FLG_V};
      OP_BR_OVERFLOW_ZERO: br_dec = {3'b100, FLG_V};
      OP_BR_IRQ_ON: br_dec = {3'b101, FLG_I};
      OP_BR_IRQ_OFF: br_dec = {3'b100, FLG_I};
      OP_BR_FLAG_ONE: br_dec = {3'b101, b};
      OP_BR_FLAG_ZERO: br_dec = {3'b100, b};
      default: br_dec = 6'h00;
    endcase
  endfunction

  // {is_flag_op, new value, flag index}
  function automatic logic [4:0] fl_dec(input bbo_op_t op,
                                        input logic [2:0] b);
    case (op)
      OP_FLAG_SET_GENERIC: fl_dec = {2'b11, b};
      OP_FLAG_CLEAR_GENERIC: fl_dec = {2'b10, b};
      OP_IRQ_ENABLE: fl_dec = {2'b11, FLG_I};
      OP_IRQ_DISABLE: fl_dec = {2'b10, FLG_I};
      OP_SIGNED_FLAG_SET: fl_dec = {2'b11, FLG_S};
      OP_SIGNED_FLAG_CLEAR: fl_dec = {2'b10, FLG_S};
      OP_OVERFLOW_SET: fl_dec = {2'b11, FLG_V};
      OP_OVERFLOW_CLEAR: fl_dec = {2'b10, FLG_V};
      OP_CARRY_SET: fl_dec = {2'b11, FLG_C};
      OP_CARRY_CLEAR: fl_dec = {2'b10, FLG_C};
      OP_NEGATIVE_SET: fl_dec = {2'b11, FLG_N};
      OP_NEGATIVE_CLEAR: fl_dec = {2'b10, FLG_N};
      OP_ZERO_SET: fl_dec = {2'b11, FLG_Z};
      OP_ZERO_CLEAR: fl_dec = {2'b10, FLG_Z};
      OP_TRANSFER_SET: fl_dec = {2'b11, FLG_T};
      OP_TRANSFER_CLEAR: fl_dec = {2'b10, FLG_T};
      OP_HALFCARRY_SET: fl_dec = {2'b11, FLG_H};
      OP_HALFCARRY_CLEAR: fl_dec = {2'b10, FLG_H};
      default: fl_dec = 5'h00;
    endcase
  endfunction

  // {reg write, flag update, carry out, result}
  function automatic logic [10:0] sh_dec(input bbo_op_t op,
                                         input logic [7:0] v,
                                         input logic c,
                                         input logic t,
                                         input logic [2:0] b);
    logic [7:0] ins;
    ins = v;
    ins[b] = t;
    case (op)
      OP_LOGICAL_LEFT_SHIFT: sh_dec = {2'b11, v[7], v[6:0], 1'b0};
      OP_LOGICAL_RIGHT_SHIFT: sh_dec = {2'b11, v[0], 1'b0, v[7:1]};
      OP_ROTATE_LEFT_CARRY: sh_dec = {2'b11, v[7], v[6:0], c};
      OP_ROTATE_RIGHT_CARRY: sh_dec = {2'b11, v[0], c, v[7:1]};
      OP_ARITH_RIGHT_SHIFT: sh_dec = {2'b11, v[0], v[7], v[7:1]};
      OP_NIBBLE_SWAP: sh_dec = {3'b100, v[3:0], v[7:4]};
      OP_TRANSFER_TO_BIT: sh_dec = {3'b100, ins};
      default: sh_dec = 11'h000;
    endcase
  endfunction

  // =====================================================
  // decode and datapath
  bbo_state_t state_q, state_d;
  logic [5:0] br_w;
  logic [4:0] fl_w;
  logic [10:0] sh_w;
  logic accept, is_br, br_hit, is_io, is_bst, two_cyc;
  logic [15:0] target;
  logic [7:0] sh_res, io_new, status_flags_register_new;
  logic sh_c, sh_n;

  assign accept = i_start && (state_q == ST_IDLE);
  assign br_w = br_dec(i_op, i_bit);
  assign fl_w = fl_dec(i_op, i_bit);
  assign sh_w = sh_dec(i_op, i_reg_val, i_status_flags_register[FLG_C], i_status_flags_register[FLG_T],
                       i_bit);
  assign is_br = br_w[5];
  // signed tests compare N xor V against the polarity
  assign br_hit = br_w[4] ?
    ((i_status_flags_register[FLG_N] ^ i_status_flags_register[FLG_V]) == br_w[3]) :
    (i_status_flags_register[br_w[2:0]] == br_w[3]);
  assign target = 16'(i_pc + {{9{i_offset[6]}}, i_offset} + PC_STEP);
  assign is_io = (i_op == OP_IO_BIT_SET) || (i_op == OP_IO_BIT_CLEAR);
  assign is_bst = (i_op == OP_BIT_TO_TRANSFER);
  assign two_cyc = (is_br && br_hit) || is_io;
  assign sh_res = sh_w[7:0];
  assign sh_c = sh_w[8];
  assign sh_n = sh_res[7];

  always_comb begin
    io_new = i_io_val;
    io_new[i_bit] = (i_op == OP_IO_BIT_SET);
  end

  always_comb begin
    status_flags_register_new = i_status_flags_register;
    if (sh_w[9]) begin
      status_flags_register_new[FLG_Z] = (sh_res == BYTE_RST);
      status_flags_register_new[FLG_C] = sh_c;
      status_flags_register_new[FLG_N] = sh_n;
      status_flags_register_new[FLG_V] = sh_n ^ sh_c;
    end
    if (fl_w[4]) begin
      status_flags_register_new[fl_w[2:0]] = fl_w[3];
    end
    if (is_bst) begin
      status_flags_register_new[FLG_T] = i_reg_val[i_bit];
    end
  end

  // =====================================================
  // control state
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = (accept && two_cyc) ? ST_HOLD : ST_IDLE;
      ST_HOLD: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  logic pend_pc_q, pend_io_q, hold;
  assign hold = (state_q == ST_HOLD);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      pend_pc_q <= 1'b0;
      pend_io_q <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_pc_load <= 1'b0;
      o_status_flags_register_we <= 1'b0;
      o_reg_we <= 1'b0;
      o_io_we <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_pc_q <= accept && is_br && br_hit;
      pend_io_q <= accept && is_io;
      o_busy <= accept && two_cyc;
      o_done <= (accept && !two_cyc) || hold;
      o_pc_load <= hold && pend_pc_q;
      o_io_we <= hold && pend_io_q;
      o_status_flags_register_we <= accept && (sh_w[9] || fl_w[4] || is_bst);
      o_reg_we <= accept && sh_w[10];
    end
  end

  // data outputs are loaded at acceptance and stand until the next
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= PC_RST;
      o_status_flags_register <= BYTE_RST;
      o_reg_val <= BYTE_RST;
      o_io_addr <= IO_ADDR_RST;
      o_io_val <= BYTE_RST;
    end else if (accept) begin
      o_pc <= target;
      o_status_flags_register <= status_flags_register_new;
      o_reg_val <= sh_res;
      o_io_addr <= i_io_addr;
      o_io_val <= io_new;
    end
  end

  // =====================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_br_taken_time: assert property (
    accept && is_br && br_hit |=> o_busy && !o_pc_load
      ##1 o_pc_load && o_done && o_pc == $past(target, 2))
    else $error("taken branch timing or target wrong");
  a_br_not_taken: assert property (
    accept && is_br && !br_hit |=> o_done && !o_pc_load && !o_status_flags_register_we)
    else $error("untaken branch not single cycle");
  a_signed_ge_hit: assert property (
    accept && i_op == OP_BR_SIGNED_GE && i_status_flags_register[FLG_N] == i_status_flags_register[FLG_V]
      |=> ##1 o_pc_load)
    else $error("signed ge branch not taken");
  a_signed_lt_hit: assert property (
    accept && i_op == OP_BR_SIGNED_LT && i_status_flags_register[FLG_N] != i_status_flags_register[FLG_V]
      |=> ##1 o_pc_load)
    else $error("signed lt branch not taken");
  a_io_bit_write: assert property (
    accept && is_io |=> !o_io_we && !o_status_flags_register_we ##1 o_io_we
      && o_io_val == $past(io_new, 2) && o_io_addr == $past(i_io_addr, 2))
    else $error("io bit write wrong");
  a_rotate_left: assert property (
    accept && i_op == OP_ROTATE_LEFT_CARRY |=> o_reg_we
      && o_reg_val == {$past(i_reg_val[6:0]), $past(i_status_flags_register[FLG_C])}
      && o_status_flags_register[FLG_C] == $past(i_reg_val[7]))
    else $error("rotate left wrong");
  a_rotate_right: assert property (
    accept && i_op == OP_ROTATE_RIGHT_CARRY |=> o_reg_we
      && o_reg_val == {$past(i_status_flags_register[FLG_C]), $past(i_reg_val[7:1])}
      && o_status_flags_register[FLG_C] == $past(i_reg_val[0]))
    else $error("rotate right wrong");
  a_arith_shift: assert property (
    accept && i_op == OP_ARITH_RIGHT_SHIFT |=> o_reg_val[7] == o_reg_val[6]
      && o_status_flags_register[FLG_V] == (o_status_flags_register[FLG_N] ^ o_status_flags_register[FLG_C])
      && o_reg_val == {$past(i_reg_val[7]), $past(i_reg_val[7:1])}
      && o_status_flags_register[FLG_C] == $past(i_reg_val[0]))
    else $error("arithmetic shift wrong");
  a_bit_store: assert property (
    accept && is_bst |=> o_status_flags_register_we && !o_reg_we
      && o_status_flags_register[FLG_T] == $past(i_reg_val[i_bit])
      && ((o_status_flags_register ^ $past(i_status_flags_register)) & ~(8'h01 << FLG_T)) == 8'h00)
    else $error("bit store wrong");
  a_irq_enable: assert property (
    accept && i_op == OP_IRQ_ENABLE
      |=> o_status_flags_register == ($past(i_status_flags_register) | 8'h80) && o_done)
    else $error("interrupt enable wrong");

  c_br_taken: cover property (accept && is_br && br_hit ##2 o_pc_load);
  c_io_write: cover property (accept && is_io ##2 o_io_we);
  c_back_to_back: cover property (accept && !two_cyc ##1 accept);
  c_bit_load: cover property (accept && i_op == OP_TRANSFER_TO_BIT);

endmodule // bbo_unit

// File: bbo_tb.sv
// self-checking testbench for the branch, bit and shift unit
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbo_pkg::*;

  // =====================================================
  // design ports
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  bbo_op_t i_op = OP_NOP;
  logic [15:0] i_pc = 16'h0000;
  logic [6:0] i_offset = 7'h00;
  logic [2:0] i_bit = 3'h0;
  logic [7:0] i_status_flags_register = 8'h00;
  logic [7:0] i_reg_val = 8'h00;
  logic [4:0] i_io_addr = 5'h00;
  logic [7:0] i_io_val = 8'h00;
  logic o_busy, o_done, o_pc_load, o_status_flags_register_we, o_reg_we, o_io_we;
  logic [15:0] o_pc;
  logic [7:0] o_status_flags_register, o_reg_val, o_io_val;
  logic [4:0] o_io_addr;

  // =====================================================
  // bench state
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] st = 32'h0000_0023;
  logic e_two, e_pcld, e_swe, e_rwe, e_iowe;
  logic [15:0] e_pc;
  logic [7:0] e_status_flags_register, e_reg, e_io;
  // expected strobe pattern per request: pc, flags, register, i/o
  logic [3:0] exp_q[$];
  logic [3:0] e_stb;

  always #10 i_clk = ~i_clk;

  bbo_unit bbo_unit_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
    .i_pc(i_pc), .i_offset(i_offset), .i_bit(i_bit), .i_status_flags_register(i_status_flags_register),
    .i_reg_val(i_reg_val), .i_io_addr(i_io_addr), .i_io_val(i_io_val),
    .o_busy(o_busy), .o_done(o_done), .o_pc(o_pc), .o_pc_load(o_pc_load),
    .o_status_flags_register(o_status_flags_register), .o_status_flags_register_we(o_status_flags_register_we), .o_reg_val(o_reg_val),
    .o_reg_we(o_reg_we), .o_io_addr(o_io_addr), .o_io_val(o_io_val),
    .o_io_we(o_io_we)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // =====================================================
  // reference model of one request
  task automatic predict();
    logic [7:0] f, r, res;
    logic c, tk, fl, fv, rw, isio, isbr, sh;
    logic [2:0] fi;
    f = i_status_flags_register;
    r = i_reg_val;
    res = r;
    {c, tk, fl, fv, rw, isio, fi} = 9'h000;
    case (i_op)
      OP_BR_EQUAL: tk = f[FLG_Z];
      OP_BR_NOT_EQUAL: tk = !f[FLG_Z];
      OP_BR_CARRY_ONE, OP_BR_UNSIGNED_LT: tk = f[FLG_C];
      OP_BR_CARRY_ZERO, OP_BR_UNSIGNED_GE: tk = !f[FLG_C];
      OP_BR_NEGATIVE: tk = f[FLG_N];
      OP_BR_NONNEGATIVE: tk = !f[FLG_N];
      OP_BR_SIGNED_GE: tk = !(f[FLG_N] ^ f[FLG_V]);
      OP_BR_SIGNED_LT: tk = f[FLG_N] ^ f[FLG_V];
      OP_BR_HALFCARRY_ONE: tk = f[FLG_H];
      OP_BR_HALFCARRY_ZERO: tk = !f[FLG_H];
      OP_BR_TRANSFER_ONE: tk = f[FLG_T];
      OP_BR_TRANSFER_ZERO: tk = !f[FLG_T];
      OP_BR_OVERFLOW_ONE: tk = f[FLG_V];
      OP_BR_OVERFLOW_ZERO: tk = !f[FLG_V];
      OP_BR_IRQ_ON: tk = f[FLG_I];
      OP_BR_IRQ_OFF: tk = !f[FLG_I];
      OP_BR_FLAG_ONE: tk = f[i_bit];
      OP_BR_FLAG_ZERO: tk = !f[i_bit];
      OP_IO_BIT_SET: {isio, fv} = 2'b11;
      OP_IO_BIT_CLEAR: {isio, fv} = 2'b10;
      OP_LOGICAL_LEFT_SHIFT: {c, res} = {r, 1'b0};
      OP_LOGICAL_RIGHT_SHIFT: {res, c} = {1'b0, r};
      OP_ROTATE_LEFT_CARRY: {c, res} = {r, f[FLG_C]};
      OP_ROTATE_RIGHT_CARRY: {res, c} = {f[FLG_C], r};
      OP_ARITH_RIGHT_SHIFT: {res, c} = {r[7], r};
      OP_NIBBLE_SWAP: {rw, res} = {1'b1, r[3:0], r[7:4]};
      OP_FLAG_SET_GENERIC: {fl, fi, fv} = {1'b1, i_bit, 1'b1};
      OP_FLAG_CLEAR_GENERIC: {fl, fi, fv} = {1'b1, i_bit, 1'b0};
      OP_BIT_TO_TRANSFER: {fl, fi, fv} = {1'b1, FLG_T, r[i_bit]};
      OP_TRANSFER_TO_BIT: rw = 1'b1;
      OP_IRQ_ENABLE: {fl, fi, fv} = {1'b1, FLG_I, 1'b1};
      OP_IRQ_DISABLE: {fl, fi, fv} = {1'b1, FLG_I, 1'b0};
      OP_SIGNED_FLAG_SET: {fl, fi, fv} = {1'b1, FLG_S, 1'b1};
      OP_SIGNED_FLAG_CLEAR: {fl, fi, fv} = {1'b1, FLG_S, 1'b0};
      OP_OVERFLOW_SET: {fl, fi, fv} = {1'b1, FLG_V, 1'b1};
      OP_OVERFLOW_CLEAR: {fl, fi, fv} = {1'b1, FLG_V, 1'b0};
      OP_CARRY_SET: {fl, fi, fv} = {1'b1, FLG_C, 1'b1};
      OP_CARRY_CLEAR: {fl, fi, fv} = {1'b1, FLG_C, 1'b0};
      OP_NEGATIVE_SET: {fl, fi, fv} = {1'b1, FLG_N, 1'b1};
      OP_NEGATIVE_CLEAR: {fl, fi, fv} = {1'b1, FLG_N, 1'b0};
      OP_ZERO_SET: {fl, fi, fv} = {1'b1, FLG_Z, 1'b1};
      OP_ZERO_CLEAR: {fl, fi, fv} = {1'b1, FLG_Z, 1'b0};
      OP_TRANSFER_SET: {fl, fi, fv} = {1'b1, FLG_T, 1'b1};
      OP_TRANSFER_CLEAR: {fl, fi, fv} = {1'b1, FLG_T, 1'b0};
      OP_HALFCARRY_SET: {fl, fi, fv} = {1'b1, FLG_H, 1'b1};
      OP_HALFCARRY_CLEAR: {fl, fi, fv} = {1'b1, FLG_H, 1'b0};
      default: tk = 1'b0;
    endcase
    if (i_op == OP_TRANSFER_TO_BIT) res[i_bit] = f[FLG_T];
    sh = i_op inside {[OP_LOGICAL_LEFT_SHIFT:OP_ARITH_RIGHT_SHIFT]};
    isbr = i_op inside {[OP_BR_EQUAL:OP_BR_FLAG_ZERO]};
    e_status_flags_register = f;
    if (sh) e_status_flags_register[3:0] = {res[7] ^ c, res[7], res == 8'h00, c};
    if (fl) e_status_flags_register[fi] = fv;
    e_swe = sh || fl;
    e_rwe = sh || rw;
    e_reg = res;
    e_io = i_io_val;
    e_io[i_bit] = fv;
    e_iowe = isio;
    e_pcld = isbr && tk;
    e_two = e_pcld || isio;
    e_pc = i_pc + {{9{i_offset[6]}}, i_offset} + PC_STEP;
    exp_q.push_back({e_pcld, e_swe, e_rwe, e_iowe});
  endtask

  // =====================================================
  // one request; start stays high through busy to probe refusal
  task automatic run_op(input bbo_op_t op);
    st = xs(st);
    {i_offset, i_bit, i_io_addr, i_status_flags_register, i_reg_val} = st[30:0];
    st = xs(st);
    {i_pc, i_io_val} = st[23:0];
    i_op = op;
    i_start = 1'b1;
    predict();
    @(negedge i_clk);
    `CHK("busy", e_two, o_busy)
    if (e_two) begin
      `CHK("early_done", 1'b0, o_done)
      @(negedge i_clk);
    end
    e_stb = exp_q.pop_front();
    `CHK("strobes", e_stb, {o_pc_load, o_status_flags_register_we, o_reg_we, o_io_we})
    `CHK("done", 1'b1, o_done)
    `CHK("pc_load", e_pcld, o_pc_load)
    `CHK("status_flags_register_we", e_swe, o_status_flags_register_we)
    `CHK("reg_we", e_rwe, o_reg_we)
    `CHK("io_we", e_iowe, o_io_we)
    if (e_pcld) `CHK("pc", e_pc, o_pc)
    if (e_swe) `CHK("status_flags_register", e_status_flags_register, o_status_flags_register)
    if (e_rwe) `CHK("reg", e_reg, o_reg_val)
    if (e_iowe) `CHK("io_val", e_io, o_io_val)
    if (e_iowe) `CHK("io_addr", i_io_addr, o_io_addr)
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    `CHK("rst_done", 1'b0, o_done)
    `CHK("rst_pc", 16'h0000, o_pc)
    for (int i = 0; i < 49; i++) begin
      run_op(bbo_op_t'(6'(i)));
    end
    repeat (1500) begin
      st = xs(st);
      if (st[2:0] == 3'h0) begin
        i_start = 1'b0;
        @(negedge i_clk);
      end
      run_op(bbo_op_t'(6'(st % 49)));
    end
    i_start = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("idle_done", 1'b0, o_done)
    complete_run();
  end
endmodule // testbench
